//--- design/cwd_params.svh
// register addresses, field positions, reset values and timing
// constants for the communication-loss watchdog.
// assumes register addresses arrive as 16-bit word addresses.
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CWD_ADDR_ARM        16'hF0A0
`define CWD_ADDR_ADV        16'hF0A2
`define CWD_ADDR_TIMEOUT    16'hF0A4
`define CWD_ADDR_STRICT_EN  16'hF0AA
`define CWD_ADDR_STRICT_KEY 16'hF0AC
`define CWD_ADDR_STRICT_CLR 16'hF0AE
`define CWD_ADDR_RST_EN     16'hF0B4
`define CWD_ADDR_DIG_EN     16'hF0BE
`define CWD_ADDR_DIG_LVL    16'hF0C0
`define CWD_ADDR_DIG_DIR    16'hF0C2
`define CWD_ADDR_DIG_MASK   16'hF0C4
`define CWD_ADDR_AO0_EN     16'hF0C8
`define CWD_ADDR_AO0_VOLTS  16'hF0CA
`define CWD_ADDR_AO1_EN     16'hF0D2
`define CWD_ADDR_AO1_VOLTS  16'hF0D4

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define CWD_ADV_FACTORY_BIT 0
`define CWD_ADV_SAVED_BIT   1
`define CWD_ENABLE_VALUE    32'h00000001
`define CWD_RESET_WORD      32'h00000000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CWD_SECOND_NS 1000000000
`define CWD_CLK_NS    25

`endif

//--- design/cwd_pkg.sv
// types shared by the watchdog modules.
// assumes cwd_params.svh supplies all numeric constants.
package cwd_pkg;

    // ----------------------------------------------------------------
    // register select
    // ----------------------------------------------------------------
    typedef enum {
        CWD_SEL_NONE, CWD_SEL_ARM, CWD_SEL_ADV, CWD_SEL_TIMEOUT,
        CWD_SEL_STRICT_EN, CWD_SEL_STRICT_KEY, CWD_SEL_STRICT_CLR,
        CWD_SEL_RST_EN, CWD_SEL_DIG_EN, CWD_SEL_DIG_LVL, CWD_SEL_DIG_DIR,
        CWD_SEL_DIG_MASK, CWD_SEL_AO0_EN, CWD_SEL_AO0_VOLTS,
        CWD_SEL_AO1_EN, CWD_SEL_AO1_VOLTS
    } cwd_sel_t;

    // ----------------------------------------------------------------
    // state of the main module
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] arm, adv, timeout, strictEn, key, rstEn;
        logic [31:0] digEn, digLvl, digDir, digMask;
        logic [31:0] ao0En, ao0Volts, ao1En, ao1Volts;
        logic [31:0] secCnt, rdData;
        logic rdValid, expired, resetReq, digApply;
        logic ao0Apply, ao1Apply, restoreFactory, restoreSaved;
    } cwd_state_t;

    // ----------------------------------------------------------------
    // state of the prescaler
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } cwd_presc_t;

endpackage

//--- design/cwd_tick_if.sv
// link between the watchdog core and its one-second prescaler.
// assumes both ends share core_clk.
`timescale 1ns/10ps
interface cwd_tick_if;
    logic run;
    logic restart;
    logic tick;
    modport gen (input run, input restart, output tick);
    modport user (output run, output restart, input tick);
endinterface

//--- design/cwd_tick.sv
// one-second prescaler for the watchdog.
// assumes core_clk at the rate named by TICK_CYCLES per second.
`timescale 1ns/10ps
module cwd_tick #(
    parameter int unsigned TICK_CYCLES = 40000000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // core side
    cwd_tick_if.gen tk
);
    import cwd_pkg::*;

    cwd_presc_t q;
    cwd_presc_t d;

    // ----------------------------------------------------------------
    // count
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (tk.restart || !tk.run) begin
            d.cnt = 32'h00000000;
        end else if (q.cnt == 32'(TICK_CYCLES - 1)) begin
            d.cnt = 32'h00000000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 32'h00000001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign tk.tick = q.tick;
endmodule

//--- design/cwd_top.sv
// communication-loss watchdog: registers, seconds counter, timeout
// actions.
// assumes a register port fed by the host protocol engine and
// one-cycle activity pulses from the link layers.
`timescale 1ns/10ps
`include "cwd_params.svh"

// Notes on behaviour
// - enable register arms or disarms watchdog
// - timeout held as whole seconds
// - host communication clears timer unless strict
// - expiry performs every enabled action
// - reply restarts period unless strict
// - reset action requests device restart
// - digital action updates digital lines
// - lines take stored level and direction
// - masked lines left untouched
// - analog output 0 forced to stored volts
// - analog output 1 forced to stored volts
// - advanced bits restore factory or saved
// - strict mode clears only on key write
// - streamed data never restarts period
module cwd_top #(
    parameter int unsigned TICK_CYCLES = `CWD_SECOND_NS / `CWD_CLK_NS,
    parameter int unsigned DIG_W = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // host activity
    input wire logic hostRxActivity,
    input wire logic replySent,
    // status
    output logic armed,
    output logic [31:0] elapsedSeconds,
    output logic expired,
    // timeout actions
    output logic deviceResetReq,
    output logic digitalApply,
    output logic [DIG_W-1:0] digitalLevel,
    output logic [DIG_W-1:0] digitalDirection,
    output logic [DIG_W-1:0] digitalWriteMask,
    output logic analogOut0Apply,
    output logic [31:0] analogOut0Volts,
    output logic analogOut1Apply,
    output logic [31:0] analogOut1Volts,
    output logic restoreFactorySettings,
    output logic restoreSavedSettings
);
    import cwd_pkg::*;

    // registered state and its next value
    cwd_state_t q;
    cwd_state_t d;
    // prescaler link
    cwd_tick_if tk ();
    // decoded controls
    logic armedNow;
    logic strictNow;
    logic clrWrite;
    logic kick;
    logic [31:0] nextSec;
    logic hostKick;
    logic keyKick;
    logic periodDone;
    cwd_sel_t wrSel;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic cwd_sel_t decodeAddr(input logic [15:0] a);
        case (a)
            `CWD_ADDR_ARM: decodeAddr = CWD_SEL_ARM;
            `CWD_ADDR_ADV: decodeAddr = CWD_SEL_ADV;
            `CWD_ADDR_TIMEOUT: decodeAddr = CWD_SEL_TIMEOUT;
            `CWD_ADDR_STRICT_EN: decodeAddr = CWD_SEL_STRICT_EN;
            `CWD_ADDR_STRICT_KEY: decodeAddr = CWD_SEL_STRICT_KEY;
            `CWD_ADDR_STRICT_CLR: decodeAddr = CWD_SEL_STRICT_CLR;
            `CWD_ADDR_RST_EN: decodeAddr = CWD_SEL_RST_EN;
            `CWD_ADDR_DIG_EN: decodeAddr = CWD_SEL_DIG_EN;
            `CWD_ADDR_DIG_LVL: decodeAddr = CWD_SEL_DIG_LVL;
            `CWD_ADDR_DIG_DIR: decodeAddr = CWD_SEL_DIG_DIR;
            `CWD_ADDR_DIG_MASK: decodeAddr = CWD_SEL_DIG_MASK;
            `CWD_ADDR_AO0_EN: decodeAddr = CWD_SEL_AO0_EN;
            `CWD_ADDR_AO0_VOLTS: decodeAddr = CWD_SEL_AO0_VOLTS;
            `CWD_ADDR_AO1_EN: decodeAddr = CWD_SEL_AO1_EN;
            `CWD_ADDR_AO1_VOLTS: decodeAddr = CWD_SEL_AO1_VOLTS;
            default: decodeAddr = CWD_SEL_NONE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    function automatic logic [31:0] readReg(input cwd_sel_t s, input cwd_state_t r);
        case (s)
            CWD_SEL_ARM: readReg = r.arm;
            CWD_SEL_ADV: readReg = r.adv;
            CWD_SEL_TIMEOUT: readReg = r.timeout;
            CWD_SEL_STRICT_EN: readReg = r.strictEn;
            CWD_SEL_STRICT_KEY: readReg = r.key;
            CWD_SEL_RST_EN: readReg = r.rstEn;
            CWD_SEL_DIG_EN: readReg = r.digEn;
            CWD_SEL_DIG_LVL: readReg = r.digLvl;
            CWD_SEL_DIG_DIR: readReg = r.digDir;
            CWD_SEL_DIG_MASK: readReg = r.digMask;
            CWD_SEL_AO0_EN: readReg = r.ao0En;
            CWD_SEL_AO0_VOLTS: readReg = r.ao0Volts;
            CWD_SEL_AO1_EN: readReg = r.ao1En;
            CWD_SEL_AO1_VOLTS: readReg = r.ao1Volts;
            // strict clear is write-only and reads zero
            default: readReg = `CWD_RESET_WORD;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // enable decode
    // ----------------------------------------------------------------
    // enable and arm words act only on exactly one
    function automatic logic isOn(input logic [31:0] v);
        isOn = (v == `CWD_ENABLE_VALUE);
    endfunction

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // restarts on every kick so a full second follows
    cwd_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .resetn(resetn),
        .ce(ce),
        .tk(tk)
    );

    // ----------------------------------------------------------------
    // kick sources
    // ----------------------------------------------------------------
    // armed only on one
    assign armedNow = isOn(q.arm);
    assign strictNow = isOn(q.strictEn);
    assign wrSel = regWrEn ? decodeAddr(regAddr) : CWD_SEL_NONE;
    assign clrWrite = (wrSel == CWD_SEL_STRICT_CLR);
    assign hostKick = hostRxActivity || replySent || clrWrite;
    // key write only
    // key compare sees the key before a same-cycle key write
    assign keyKick = clrWrite && (regWrData == q.key);

    always_comb begin
        if (strictNow) begin
            kick = keyKick;
        end else begin
            kick = hostKick;
        end
    end

    assign tk.run = armedNow;
    assign tk.restart = kick || !armedNow;
    assign nextSec = q.secCnt + 32'h00000001;

    // ----------------------------------------------------------------
    // period end
    // ----------------------------------------------------------------
    // a kick in the tick cycle wins; timeout zero acts as one second
    assign periodDone = armedNow && !kick && tk.tick && (nextSec >= q.timeout);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdValid = 1'b0;
        d.expired = 1'b0;
        d.resetReq = 1'b0;
        d.digApply = 1'b0;
        d.ao0Apply = 1'b0;
        d.ao1Apply = 1'b0;
        d.restoreFactory = 1'b0;
        d.restoreSaved = 1'b0;

        // ------------------------------------------------------------
        // register writes; disarm-first ordering is the host's job
        // ------------------------------------------------------------
        if (regWrEn) begin
            case (wrSel)
                CWD_SEL_ARM: d.arm = regWrData;
                CWD_SEL_ADV: d.adv = regWrData;
                CWD_SEL_TIMEOUT: d.timeout = regWrData;
                CWD_SEL_STRICT_EN: d.strictEn = regWrData;
                CWD_SEL_STRICT_KEY: d.key = regWrData;
                CWD_SEL_RST_EN: d.rstEn = regWrData;
                CWD_SEL_DIG_EN: d.digEn = regWrData;
                CWD_SEL_DIG_LVL: d.digLvl = regWrData;
                CWD_SEL_DIG_DIR: d.digDir = regWrData;
                CWD_SEL_DIG_MASK: d.digMask = regWrData;
                CWD_SEL_AO0_EN: d.ao0En = regWrData;
                CWD_SEL_AO0_VOLTS: d.ao0Volts = regWrData;
                CWD_SEL_AO1_EN: d.ao1En = regWrData;
                CWD_SEL_AO1_VOLTS: d.ao1Volts = regWrData;
                default: d.rdValid = 1'b0;
            endcase
        end

        // ------------------------------------------------------------
        // register reads, one cycle later
        // ------------------------------------------------------------
        if (regRdEn) begin
            d.rdValid = 1'b1;
            d.rdData = readReg(decodeAddr(regAddr), q);
        end

        // ------------------------------------------------------------
        // seconds counter
        // ------------------------------------------------------------
        if (!armedNow || kick) begin
            d.secCnt = 32'h00000000;
        end else if (tk.tick) begin
            if (periodDone) begin
                // perform enabled actions
                // action pulses stretch while ce is low
                d.expired = 1'b1;
                d.resetReq = isOn(q.rstEn);
                d.digApply = isOn(q.digEn);
                d.ao0Apply = isOn(q.ao0En);
                d.ao1Apply = isOn(q.ao1En);
                d.restoreFactory = q.adv[`CWD_ADV_FACTORY_BIT];
                d.restoreSaved = q.adv[`CWD_ADV_SAVED_BIT];
                d.secCnt = 32'h00000000;
            end else begin
                d.secCnt = nextSec;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // register port
    assign regRdData = q.rdData;
    assign regRdValid = q.rdValid;
    // status
    assign armed = armedNow;
    assign elapsedSeconds = q.secCnt;
    assign expired = q.expired;
    // actions
    assign deviceResetReq = q.resetReq;
    assign digitalApply = q.digApply;
    assign analogOut0Apply = q.ao0Apply;
    assign analogOut0Volts = q.ao0Volts;
    assign analogOut1Apply = q.ao1Apply;
    assign analogOut1Volts = q.ao1Volts;
    assign restoreFactorySettings = q.restoreFactory;
    assign restoreSavedSettings = q.restoreSaved;

    // ----------------------------------------------------------------
    // digital lines
    // ----------------------------------------------------------------
    for (genvar i = 0; i < DIG_W; i++) begin : g_line
        assign digitalLevel[i] = q.digLvl[i];
        assign digitalDirection[i] = q.digDir[i];
        assign digitalWriteMask[i] = !q.digMask[i];
    end
endmodule

//--- dv/cwd_top_properties.sv
// checker on the watchdog top ports.
// assumes core_clk with resetn as the only domain; bound onto cwd_top.
`timescale 1ns/10ps
module cwd_top_checker #(
    parameter int unsigned TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // register port
    input wire logic regRdEn,
    input wire logic regRdValid,
    // status and actions
    input wire logic armed,
    input wire logic [31:0] elapsedSeconds,
    input wire logic expired,
    input wire logic deviceResetReq,
    input wire logic digitalApply,
    input wire logic analogOut0Apply,
    input wire logic analogOut1Apply,
    input wire logic restoreFactorySettings,
    input wire logic restoreSavedSettings
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [31:0] gapCnt_q;
    logic [31:0] secPrev_q;
    // ce-enabled cycles since the seconds count last changed
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gapCnt_q <= '0;
            secPrev_q <= '0;
        end else begin
            secPrev_q <= elapsedSeconds;
            gapCnt_q <= (elapsedSeconds != secPrev_q) ? 32'h1 : gapCnt_q + {31'h0, ce};
        end
    end
    a_idle_no_expiry: assert property (!$past(armed) |-> !expired)
        else $error("expiry while disarmed");
    a_count_steps: assert property (elapsedSeconds != secPrev_q |->
        elapsedSeconds == 32'h0 || elapsedSeconds == secPrev_q + 32'h1)
        else $error("seconds count jumped");
    a_tick_spacing: assert property (elapsedSeconds == secPrev_q + 32'h1
        |-> gapCnt_q >= TICK_CYCLES) else $error("second ticked too early");
    a_expiry_clears: assert property (expired |-> elapsedSeconds == 32'h0)
        else $error("count not cleared on expiry");
    a_single_expiry: assert property (expired && ce |=> !expired)
        else $error("expiry pulse too long");
    a_reset_on_expiry: assert property (deviceResetReq |-> expired)
        else $error("reset request without expiry");
    a_digital_on_expiry: assert property (digitalApply |-> expired)
        else $error("digital apply without expiry");
    a_analog_on_expiry: assert property (analogOut0Apply || analogOut1Apply
        |-> expired) else $error("analog apply without expiry");
    a_restore_on_expiry: assert property (restoreFactorySettings ||
        restoreSavedSettings |-> expired) else $error("restore without expiry");
    a_read_answer: assert property (regRdEn && ce |=> regRdValid)
        else $error("read not answered");
    c_reset_expiry: cover property (expired && deviceResetReq);
    c_quiet_expiry: cover property (expired && !digitalApply);
    c_read_done: cover property (regRdValid);
endmodule

bind cwd_top cwd_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
    .core_clk(core_clk), .resetn(resetn), .ce(ce), .regRdEn(regRdEn),
    .regRdValid(regRdValid), .armed(armed), .elapsedSeconds(elapsedSeconds),
    .expired(expired), .deviceResetReq(deviceResetReq), .digitalApply(digitalApply),
    .analogOut0Apply(analogOut0Apply), .analogOut1Apply(analogOut1Apply),
    .restoreFactorySettings(restoreFactorySettings),
    .restoreSavedSettings(restoreSavedSettings));

//--- dv/cwd_host_model.sv
// host model: register accesses and link traffic pulses.
// assumes the bench calls its tasks; requests launch at a rising edge.
`timescale 1ns/10ps
module cwd_host_model (
    // clock
    input wire logic core_clk,
    // register requests
    output logic regWrEn,
    output logic regRdEn,
    output logic [15:0] regAddr,
    output logic [31:0] regWrData,
    // traffic
    output logic hostRxActivity,
    output logic replySent
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 16'h0000;
        regWrData = 32'h00000000;
        hostRxActivity = 1'b0;
        replySent = 1'b0;
    end
    // caller disarms first, periods of whole seconds
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrEn <= wr;
        regRdEn <= !wr;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    task automatic pulse(input logic reply);
        @(posedge core_clk);
        hostRxActivity <= !reply;
        replySent <= reply;
        @(posedge core_clk);
        hostRxActivity <= 1'b0;
        replySent <= 1'b0;
    endtask
endmodule

//--- dv/comm_loss_watchdog_tb.sv
// self-checking bench for the watchdog top.
// assumes a short prescale count of TICKS cycles per second.
`timescale 1ns/10ps
`include "cwd_params.svh"
module comm_loss_watchdog_tb;
    localparam int unsigned TICKS = 4;
    logic core_clk, resetn, ce, regWrEn, regRdEn, hostRxActivity, replySent;
    logic [15:0] regAddr;
    logic [31:0] regWrData, regRdData, elapsedSeconds, analogOut0Volts, analogOut1Volts;
    logic [31:0] digitalLevel, digitalDirection, digitalWriteMask;
    logic regRdValid, armed, expired, deviceResetReq, digitalApply;
    logic analogOut0Apply, analogOut1Apply, restoreFactorySettings, restoreSavedSettings;
    logic [31:0] rdQ [$];
    logic [165:0] exQ [$];
    logic [165:0] expAct;
    logic [31:0] cfg [11];
    logic [31:0] key;
    logic [15:0] cfgAddr [11] = '{`CWD_ADDR_ADV, `CWD_ADDR_TIMEOUT, `CWD_ADDR_RST_EN,
        `CWD_ADDR_DIG_EN, `CWD_ADDR_DIG_LVL, `CWD_ADDR_DIG_DIR, `CWD_ADDR_DIG_MASK,
        `CWD_ADDR_AO0_EN, `CWD_ADDR_AO0_VOLTS, `CWD_ADDR_AO1_EN, `CWD_ADDR_AO1_VOLTS};
    int error_cnt = 0;
    int comparisons = 0;
    int expCnt = 0;
    int n;
    wire logic [165:0] actNow = {deviceResetReq, digitalApply, analogOut0Apply,
        analogOut1Apply, restoreFactorySettings, restoreSavedSettings, digitalLevel,
        digitalDirection, digitalWriteMask, analogOut0Volts, analogOut1Volts};

    cwd_top #(.TICK_CYCLES(TICKS), .DIG_W(32)) DUT (.core_clk, .resetn, .ce, .regWrEn,
        .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid, .hostRxActivity,
        .replySent, .armed, .elapsedSeconds, .expired, .deviceResetReq, .digitalApply,
        .digitalLevel, .digitalDirection, .digitalWriteMask, .analogOut0Apply,
        .analogOut0Volts, .analogOut1Apply, .analogOut1Volts, .restoreFactorySettings,
        .restoreSavedSettings);
    cwd_host_model host (.core_clk, .regWrEn, .regRdEn, .regAddr, .regWrData,
        .hostRxActivity, .replySent);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [165:0] exp, input logic [165:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        host.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        rdQ.push_back(exp);
        host.access(1'b0, a, 32'h0);
    endtask
    task automatic wait_cnt(input int target);
        for (int i = 0; i < 200 && expCnt < target; i++) begin
            @(posedge core_clk);
            // random freezes of the block
            ce <= ($urandom_range(3) != 0);
        end
        @(posedge core_clk);
        ce <= 1'b1;
        if (expCnt < target) begin
            error_cnt++;
            $display("CHECK FAILED expiry count expected %0d seen %0d", target, expCnt);
            print_verdict();
        end
    endtask
    task automatic setup(input logic [31:0] secs);
        wr(`CWD_ADDR_ARM, 32'h0);
        foreach (cfg[i]) begin
            cfg[i] = (i inside {2, 3, 7, 9}) ? $urandom_range(2) : $urandom();
            if (i == 1) cfg[i] = secs;
            wr(cfgAddr[i], cfg[i]);
        end
        foreach (cfg[i]) rd(cfgAddr[i], cfg[i]);
        expAct = {cfg[2] == 32'h1, cfg[3] == 32'h1, cfg[7] == 32'h1, cfg[9] == 32'h1,
            cfg[0][0], cfg[0][1], cfg[4], cfg[5], ~cfg[6], cfg[8], cfg[10]};
    endtask

    // ----------------------------------------------------------------
    // result monitor
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (resetn === 1'b1 && ce === 1'b1 && regRdValid === 1'b1) begin
            if (rdQ.size() == 0) check("stray read", 166'h0, 166'h1);
            else check("read data", {134'h0, rdQ.pop_front()}, {134'h0, regRdData});
        end
        if (resetn === 1'b1 && ce === 1'b1 && expired === 1'b1) begin
            expCnt++;
            if (exQ.size() == 0) check("stray expiry", 166'h0, 166'h1);
            else check("expiry actions", exQ.pop_front(), actNow);
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        void'($urandom(32'hFD70CCC7));
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rd(`CWD_ADDR_TIMEOUT, 32'h0);
        rd(`CWD_ADDR_ARM, 32'h0);
        rd(16'hF0B0, 32'h0);
        rd(`CWD_ADDR_STRICT_CLR, 32'h0);
        // random action sets, two periods each, then idle while disarmed
        for (int r = 0; r < 3; r++) begin
            setup(r + 2);
            n = expCnt;
            exQ.push_back(expAct);
            exQ.push_back(expAct);
            wr(`CWD_ADDR_ARM, 32'h1);
            wait_cnt(n + 2);
            wr(`CWD_ADDR_ARM, 32'h0);
            repeat (40) @(posedge core_clk);
        end
        // traffic keeps the period from running out
        setup(3);
        wr(`CWD_ADDR_ARM, 32'h1);
        for (int k = 0; k < 9; k++) begin
            if (k % 3 == 2) wr(`CWD_ADDR_STRICT_CLR, $urandom());
            else host.pulse(k % 3);
            repeat (3) @(posedge core_clk);
        end
        n = expCnt;
        exQ.push_back(expAct);
        wait_cnt(n + 1);
        // strict mode: traffic and a wrong key are ignored
        setup(2);
        key = $urandom();
        wr(`CWD_ADDR_STRICT_EN, 32'h1);
        wr(`CWD_ADDR_STRICT_KEY, key);
        n = expCnt;
        exQ.push_back(expAct);
        exQ.push_back(expAct);
        wr(`CWD_ADDR_ARM, 32'h1);
        for (int k = 0; k < 6; k++) begin
            if (k == 5) wr(`CWD_ADDR_STRICT_CLR, key ^ 32'h1);
            else host.pulse(k % 2);
        end
        wait_cnt(n + 2);
        repeat (6) begin
            wr(`CWD_ADDR_STRICT_CLR, key);
            repeat (2) @(posedge core_clk);
        end
        wr(`CWD_ADDR_ARM, 32'h0);
        wr(`CWD_ADDR_STRICT_EN, 32'h0);
        repeat (20) @(posedge core_clk);
        print_verdict();
    end
endmodule
